// ===== design/pdm_pkg.sv
// paged data address mapper: shared constants and carrier types
// assumes a single core clock domain, synchronous active-high reset
package pdm_pkg;
    localparam int EA_W = 16;
    localparam int XADDR_W = 24;
    localparam int RPAG_W = 10;
    localparam int WPAG_W = 9;
    localparam int LOW_W = 15;
    localparam int EA_HI_BIT = 15;
    localparam logic [RPAG_W-1:0] RPAG_RESET = 10'h001;
    localparam logic [WPAG_W-1:0] WPAG_RESET = 9'h001;
    localparam logic [RPAG_W-1:0] RPAG_ZERO = 10'h000;
    localparam logic [WPAG_W-1:0] WPAG_ZERO = 9'h000;
    localparam logic [RPAG_W-1:0] PROG_PAGE_MIN = 10'h200;
    localparam int PROG_PAGE_BIT = 9;

    typedef struct packed {
        logic valid;
        logic write;
        logic [EA_W-1:0] ea;
    } pdm_req_t;

    typedef struct packed {
        logic data_valid;
        logic prog_valid;
        logic write;
        logic [XADDR_W-1:0] addr;
    } pdm_resp_t;
endpackage : pdm_pkg

// ===== design/pdm_mapper.sv
// paged data address mapper: effective address to extended data space / program window
// assumes requests and page writes synchronous to core_clk; one registered cycle of latency
//
// How it works
// [RULE_01] low half passes to page zero unchanged
// [RULE_02] translate only when top address bit set
// [RULE_03] page number placed above low fifteen bits
// [RULE_04] reads use read page, writes write page
// [RULE_05] read page 0x200 up targets program window
// [RULE_06] writes never reach program space
// [RULE_07] page zero upper access raises address trap
// [RULE_08] both page registers reset to 0x001
// [RULE_09] writing zero to a page is ignored
// [RULE_10] 16 MB data, 16 MB program reach
// [RULE_11] read page ten bits, write page nine
`timescale 1ns/1ps
module pdm_mapper #(
    parameter int RD_PAGE_W = pdm_pkg::RPAG_W,
    parameter int WR_PAGE_W = pdm_pkg::WPAG_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire pdm_pkg::pdm_req_t req,
    input wire logic rpag_we,
    input wire logic [RD_PAGE_W-1:0] rpag_wdata,
    input wire logic wpag_we,
    input wire logic [WR_PAGE_W-1:0] wpag_wdata,
    output pdm_pkg::pdm_resp_t resp,
    output logic addr_trap,
    output logic [RD_PAGE_W-1:0] read_page,
    output logic [WR_PAGE_W-1:0] write_page
);
    import pdm_pkg::*;

    // ----------------------------------------
    // width check
    // ----------------------------------------
    if (WR_PAGE_W + LOW_W != XADDR_W || RD_PAGE_W != WR_PAGE_W + 1) begin : g_bad_width
        $error("page widths do not fit the extended address");
    end

    // ----------------------------------------
    // page registers
    // ----------------------------------------
    logic [RD_PAGE_W-1:0] rpag_q;
    logic [WR_PAGE_W-1:0] wpag_q;
    wire rpag_take = rpag_we && (rpag_wdata != RPAG_ZERO); // RULE_09
    wire wpag_take = wpag_we && (wpag_wdata != WPAG_ZERO); // RULE_09

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rpag_q <= RPAG_RESET; // RULE_08
            wpag_q <= WPAG_RESET; // RULE_08
        end else if (clk_en) begin
            if (rpag_take) rpag_q <= rpag_wdata;
            if (wpag_take) wpag_q <= wpag_wdata;
        end
    end

    // ----------------------------------------
    // translation
    // ----------------------------------------
    wire upper = req.ea[EA_HI_BIT]; // RULE_02
    wire [LOW_W-1:0] low = req.ea[LOW_W-1:0];
    wire [RD_PAGE_W-1:0] page = req.write ? {1'b0, wpag_q} : rpag_q; // RULE_04 RULE_11
    wire page_zero = (page == RPAG_ZERO); // RULE_07
    wire to_prog = upper && !req.write && (rpag_q >= PROG_PAGE_MIN); // RULE_05 RULE_06
    // program window drops the selector bit, leaving a nine-bit page
    wire [RD_PAGE_W-1:0] eff_page = to_prog ? {1'b0, page[PROG_PAGE_BIT-1:0]} : page; // RULE_10
    wire [XADDR_W-1:0] xaddr_up = {eff_page[WR_PAGE_W-1:0], low}; // RULE_03
    wire [XADDR_W-1:0] xaddr_lo = {{(XADDR_W-LOW_W){1'b0}}, low}; // RULE_01
    wire trap_d = req.valid && upper && page_zero; // RULE_07
    wire go = req.valid && !trap_d;

    pdm_resp_t resp_q;
    logic trap_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resp_q <= '0;
            trap_q <= 1'b0;
        end else if (clk_en) begin
            resp_q.data_valid <= go && !to_prog;
            resp_q.prog_valid <= go && to_prog; // RULE_06
            resp_q.write <= req.write && go;
            resp_q.addr <= upper ? xaddr_up : xaddr_lo;
            trap_q <= trap_d;
        end
    end

    assign resp = resp_q;
    assign addr_trap = trap_q;
    assign read_page = rpag_q;
    assign write_page = wpag_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_low_pass;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && !req.ea[EA_HI_BIT]
        |=> resp.data_valid && resp.addr == {{(XADDR_W-EA_W){1'b0}}, $past(req.ea)};
    endproperty
    a_low_pass: assert property (p_low_pass) else $error("low half not passed through"); // RULE_01

    property p_upper_map;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.ea[EA_HI_BIT] && !req.write && rpag_q < PROG_PAGE_MIN && rpag_q != RPAG_ZERO
        |=> resp.data_valid && resp.addr[XADDR_W-1:LOW_W] == $past(rpag_q[WR_PAGE_W-1:0]);
    endproperty
    a_upper_map: assert property (p_upper_map) else $error("upper read page misplaced"); // RULE_02

    property p_write_page;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.ea[EA_HI_BIT] && req.write && wpag_q != WPAG_ZERO
        |=> resp.data_valid && resp.write && resp.addr[XADDR_W-1:LOW_W] == $past(wpag_q);
    endproperty
    a_write_page: assert property (p_write_page) else $error("write page not used"); // RULE_04

    property p_low_bits;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid |=> resp.addr[LOW_W-1:0] == $past(req.ea[LOW_W-1:0]);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low bits altered"); // RULE_03

    property p_prog;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.ea[EA_HI_BIT] && !req.write && rpag_q >= PROG_PAGE_MIN |=> resp.prog_valid;
    endproperty
    a_prog: assert property (p_prog) else $error("program window not selected"); // RULE_05

    property p_no_prog_write;
        @(posedge core_clk) disable iff (rst)
        !(resp.prog_valid && resp.write);
    endproperty
    a_no_prog_write: assert property (p_no_prog_write) else $error("write reached program space"); // RULE_06

    property p_trap;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.ea[EA_HI_BIT] && (req.write ? wpag_q == WPAG_ZERO : rpag_q == RPAG_ZERO)
        |=> addr_trap && !resp.data_valid && !resp.prog_valid;
    endproperty
    a_trap: assert property (p_trap) else $error("page zero access not trapped"); // RULE_07

    property p_reset;
        @(posedge core_clk) rst |=> read_page == RPAG_RESET && write_page == WPAG_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("page reset value wrong"); // RULE_08

    property p_zero_ignored;
        @(posedge core_clk) disable iff (rst)
        clk_en && rpag_we && rpag_wdata == RPAG_ZERO && !$past(rst) |=> read_page == $past(read_page);
    endproperty
    a_zero_ignored: assert property (p_zero_ignored) else $error("zero write changed page"); // RULE_09

    // ----------------------------------------
    // page register and translation assertions
    // ----------------------------------------
    property p_wpage_zero_ignored;
        @(posedge core_clk) disable iff (rst)
        clk_en && wpag_we && wpag_wdata == WPAG_ZERO
        |=> write_page == $past(write_page);
    endproperty
    a_wpage_zero_ignored: assert property (p_wpage_zero_ignored) else $error("zero write moved write page"); // RULE_09

    property p_rpage_load;
        @(posedge core_clk) disable iff (rst)
        clk_en && rpag_we && rpag_wdata != RPAG_ZERO
        |=> read_page == $past(rpag_wdata);
    endproperty
    a_rpage_load: assert property (p_rpage_load) else $error("read page not loaded"); // RULE_11

    property p_wpage_load;
        @(posedge core_clk) disable iff (rst)
        clk_en && wpag_we && wpag_wdata != WPAG_ZERO
        |=> write_page == $past(wpag_wdata);
    endproperty
    a_wpage_load: assert property (p_wpage_load) else $error("write page not loaded"); // RULE_11

    property p_write_not_prog;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.write |=> !resp.prog_valid;
    endproperty
    a_write_not_prog: assert property (p_write_not_prog) else $error("write sent to program window"); // RULE_06

    property p_prog_addr;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.ea[EA_HI_BIT] && !req.write && rpag_q >= PROG_PAGE_MIN
        |=> !resp.data_valid && resp.addr[XADDR_W-1:LOW_W] == $past(rpag_q[WR_PAGE_W-1:0]);
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("program window address wrong"); // RULE_10

    property p_trap_only_upper;
        @(posedge core_clk) disable iff (rst)
        clk_en && !(req.valid && req.ea[EA_HI_BIT]) |=> !addr_trap;
    endproperty
    a_trap_only_upper: assert property (p_trap_only_upper) else $error("trap without upper access"); // RULE_07

    property p_lower_write;
        @(posedge core_clk) disable iff (rst)
        clk_en && req.valid && req.write && !req.ea[EA_HI_BIT]
        |=> resp.data_valid && resp.write && resp.addr[XADDR_W-1:LOW_W] == WPAG_ZERO;
    endproperty
    a_lower_write: assert property (p_lower_write) else $error("low half write paged"); // RULE_01

    property p_resp_exclusive;
        @(posedge core_clk) disable iff (rst)
        !(resp.data_valid && resp.prog_valid);
    endproperty
    a_resp_exclusive: assert property (p_resp_exclusive) else $error("data and program both selected"); // RULE_05

    // ----------------------------------------
    // clock enable and reset assertions
    // ----------------------------------------
    property p_reset_resp;
        @(posedge core_clk) rst |=> !resp.data_valid && !resp.prog_valid && !addr_trap;
    endproperty
    a_reset_resp: assert property (p_reset_resp) else $error("answer standing after reset"); // RULE_08

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        !clk_en
        |=> $stable(resp) && $stable(addr_trap) && $stable(read_page) && $stable(write_page);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
endmodule : pdm_mapper

// ===== tb/pdm_mem_model.sv
// far-side memory model: watches the mapper's translated accesses
// assumes resp is registered on core_clk
`timescale 1ns/1ps
module pdm_mem_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire pdm_pkg::pdm_resp_t resp,
    output logic prog_wr_q
);
    import pdm_pkg::*;
    // ----------------------------------------
    // program space is read-only
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prog_wr_q <= 1'b0;
        end else if (resp.prog_valid && resp.write) begin
            prog_wr_q <= 1'b1;
        end
    end
endmodule : pdm_mem_model

// ===== tb/pdm_mapper_tb.sv
// self-checking bench for the paged data address mapper
// assumes 20 MHz core clock and one cycle of answer latency
`timescale 1ns/1ps
module pdm_mapper_tb;
    import pdm_pkg::*;
    // ----------------------------------------
    // stimulus and rows
    // ----------------------------------------
    logic core_clk = 0, rst = 1, clk_en = 1, rpag_we = 0, wpag_we = 0, prog_wr_q;
    logic [RPAG_W-1:0] rpag_wdata = '0, read_page;
    logic [WPAG_W-1:0] wpag_wdata = '0, write_page;
    pdm_req_t req = '0;
    pdm_resp_t resp;
    logic addr_trap;
    int fails = 0, samples_checked = 0, cyc = 0;
    // write, ea, page, data_valid/prog_valid, address
    logic [52:0] rows [8] = '{
        {1'b0, 16'h1234, 10'h005, 2'b10, 24'h001234},
        {1'b0, 16'h9234, 10'h002, 2'b10, 24'h011234},
        {1'b1, 16'h8000, 10'h001, 2'b10, 24'h008000},
        {1'b0, 16'hffff, 10'h200, 2'b01, 24'h007fff},
        {1'b1, 16'hffff, 10'h1ff, 2'b10, 24'hffffff},
        {1'b0, 16'hc000, 10'h3ff, 2'b01, 24'hffc000},
        {1'b0, 16'h8001, 10'h000, 2'b01, 24'hff8001},
        {1'b1, 16'h7fff, 10'h000, 2'b10, 24'h007fff}};
    pdm_mapper DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .req(req), .rpag_we(rpag_we),
        .rpag_wdata(rpag_wdata), .wpag_we(wpag_we), .wpag_wdata(wpag_wdata), .resp(resp),
        .addr_trap(addr_trap), .read_page(read_page), .write_page(write_page));
    pdm_mem_model mem (.core_clk(core_clk), .rst(rst), .resp(resp), .prog_wr_q(prog_wr_q));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            fails++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task end_sim;
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        #1 chk("read_page", 24'(read_page), 24'h1);
        chk("write_page", 24'(write_page), 24'h1);
        foreach (rows[i]) begin
            @(posedge core_clk);
            rpag_we <= ~rows[i][52];
            wpag_we <= rows[i][52];
            rpag_wdata <= rows[i][35:26];
            wpag_wdata <= rows[i][34:26];
            @(posedge core_clk);
            rpag_we <= 0;
            wpag_we <= 0;
            req <= {1'b1, rows[i][52:36]};
            @(posedge core_clk);
            req <= '0;
            #1 chk("valid", 24'({resp.data_valid, resp.prog_valid}), 24'(rows[i][25:24]));
            chk("addr", resp.addr, rows[i][23:0]);
            chk("write", 24'(resp.write), 24'(rows[i][52]));
            chk("trap", 24'(addr_trap), 24'h0);
        end
        chk("prog_write", 24'(prog_wr_q), 24'h0);
        chk("read_page", 24'(read_page), 24'h0003ff);
        chk("write_page", 24'(write_page), 24'h0001ff);
        // page load and access on one edge: the access sees the old page
        @(posedge core_clk);
        rpag_we <= 1'b1;
        rpag_wdata <= 10'h004;
        req <= {1'b1, 1'b0, 16'h8010};
        @(posedge core_clk);
        rpag_we <= 1'b0;
        req <= '0;
        #1 chk("old_page_addr", resp.addr, 24'hff8010);
        chk("old_page_prog", 24'(resp.prog_valid), 24'h000001);
        chk("new_read_page", 24'(read_page), 24'h000004);
        // clock enable low: the standing answer and the pages hold
        @(posedge core_clk);
        req <= {1'b1, 1'b1, 16'h9000};
        @(posedge core_clk);
        clk_en <= 1'b0;
        req <= {1'b1, 1'b0, 16'h0042};
        wpag_we <= 1'b1;
        wpag_wdata <= 9'h055;
        repeat (2) @(posedge core_clk);
        clk_en <= 1'b1;
        wpag_we <= 1'b0;
        req <= '0;
        #1 chk("frozen_addr", resp.addr, 24'hff9000);
        chk("frozen_write", 24'(resp.write), 24'h000001);
        chk("frozen_page", 24'(write_page), 24'h0001ff);
        // reset in mid-run: pages back to one, first request right after
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        req <= {1'b1, 1'b0, 16'h8005};
        @(posedge core_clk);
        req <= '0;
        #1 chk("reset_read_page", 24'(read_page), 24'h000001);
        chk("reset_write_page", 24'(write_page), 24'h000001);
        chk("reset_addr", resp.addr, 24'h008005);
        chk("reset_valid", 24'({resp.data_valid, resp.prog_valid}), 24'h000002);
        end_sim();
    end
endmodule : pdm_mapper_tb
